// *** rtl/phy_gp_regs_pkg.sv ***
// Constants and carrier types for the general purpose register bank.
// Assumes a 16-bit management register port with 32 addresses and a page register at 31.
package phy_gp_regs_pkg;

  // Register addresses and paging
  localparam logic [4:0] ADDR_PAGE = 5'h1f;
  localparam logic [4:0] ADDR_PIN_LED = 5'h0e;
  localparam logic [4:0] ADDR_ALERT = 5'h13;
  localparam logic [4:0] ADDR_RECCLK = 5'h17;
  localparam logic [4:0] ADDR_DUTY = 5'h19;
  localparam logic [15:0] PAGE_MAIN = 16'h0000;
  localparam logic [15:0] PAGE_GENERAL = 16'h0010;

  // Pin direction and LED drive register fields
  localparam int HOLD_DIR_BIT = 13;
  localparam int HOLD_OUT_BIT = 12;
  localparam int HOLD_IN_BIT = 11;
  localparam int LED_TRI_BIT = 9;
  localparam logic HOLD_DIR_RESET = 1'b1;
  localparam logic HOLD_OUT_RESET = 1'b0;
  localparam logic LED_TRI_RESET = 1'b1;

  // Link drop alert field
  localparam int ALERT_LSB = 0;
  localparam logic [3:0] ALERT_ON = 4'h0;
  localparam logic [3:0] ALERT_OFF = 4'hf;

  // Recovered clock fields and codes
  localparam int RC_EN_BIT = 15;
  localparam int RC_FREQ_LSB = 8;
  localparam int RC_SQ_LSB = 4;
  localparam int RC_SRC_LSB = 0;
  localparam logic RC_EN_RESET = 1'b0;
  localparam logic [2:0] FREQ_25 = 3'h0;
  localparam logic [2:0] FREQ_125 = 3'h1;
  localparam logic [2:0] FREQ_31P25 = 3'h2;
  localparam logic [1:0] SQ_STRICT = 2'h0;
  localparam logic [1:0] SQ_RELAXED = 2'h1;
  localparam logic [1:0] SQ_LINKDOWN = 2'h2;
  localparam logic [1:0] SQ_NONE = 2'h3;
  localparam logic [2:0] SRC_RESET = 3'h0;
  localparam logic [2:0] SRC_COPPER = 3'h1;

  // LED pulse duty field and pulse timing
  localparam int DUTY_LSB = 8;
  localparam logic [7:0] DUTY_RESET = 8'h00;
  localparam logic [7:0] DUTY_MAX = 8'hc6;
  localparam logic [7:0] PHASE_LAST = 8'hc7;
  localparam logic [7:0] STEP_LAST = 8'hf9;
  localparam int NUM_LEDS = 2;

  // Link condition carried from the copper receiver logic
  typedef struct packed {
    logic up;
    logic stable;
    logic speed10;
    logic eee;
    logic lpIdle;
  } link_status_type;

  // Management register request
  typedef struct packed {
    logic [4:0] addr;
    logic write;
    logic read;
    logic [15:0] data;
  } mgmt_req_type;

endpackage

// *** rtl/phy_general_purpose_regs.sv ***
// Paged general purpose register bank: hold pin, LED drive, alert pin, recovered clock, LED duty.
// Assumes link status, LED levels and requests come from logic on core_clk; pins are asynchronous.
//
// What this block does
// - Direction bit, active low, resets 1: 1 makes hold pin input, 0 output.
// - Output hold pin drives the output data bit, which resets 0.
// - Reading the input data bit returns the present hold pin level.
// - LED tri-state bit set floats LEDs instead of high; clear drives both levels.
// - Alert field 0000 enables the link drop alert pin, 1111 disables it.
// - Recovered clock control bit 15 enables the recovered clock output.
// - Frequency field: 000 is 25 MHz, 001 125 MHz, 010 31.25 MHz.
// - Squelch 00 holds clock low: link down, unstable, 10BASE-T, or EEE.
// - Squelch 01 like 00, but allows 10BASE-T and EEE low power idle reception.
// - Squelch 10 suppresses the recovered clock only while the link is down.
// - Squelch 11 never squelches on link state; clock passes even with link down.
// - External squelch pin high suppresses the recovered clock regardless of settings.
// - Source field 001 selects copper recovered clock; other codes are reserved.
// - LED pulse duty is 0.5% plus N times 0.5%, N from 0 to 198.
// - All bank bits survive software and hardware PHY resets.
`timescale 1ns/1ps
module phy_general_purpose_regs
  import phy_gp_regs_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic phyReset,
  input wire mgmt_req_type mgmtReq,
  output logic [15:0] mgmtRdData,
  output logic mgmtRdValid,
  output logic generalPageSelected,
  input wire logic holdPinIn,
  output logic holdPinOut,
  output logic holdPinOe,
  input wire logic [NUM_LEDS-1:0] ledOn,
  input wire logic ledPulseEnable,
  output logic [NUM_LEDS-1:0] ledOut,
  output logic [NUM_LEDS-1:0] ledOe,
  input wire logic linkDropEvent,
  output logic linkDropAlertOut,
  output logic linkDropAlertOe,
  input wire link_status_type linkStatus,
  input wire logic squelchPinIn,
  output logic recClkGate,
  output logic [2:0] recClkFreqSel
);

  typedef struct packed {
    logic [15:0] page;
    logic holdDirIn;
    logic holdOutData;
    logic ledTri;
    logic [3:0] alertSel;
    logic rcEnable;
    logic [2:0] rcFreq;
    logic [1:0] rcSquelch;
    logic [2:0] rcSource;
    logic [7:0] duty;
    logic holdSync1;
    logic holdSync2;
    logic sqSync1;
    logic sqSync2;
    logic [15:0] rdData;
    logic rdValid;
    logic alertOut;
    logic rcGate;
    logic [7:0] stepCnt;
    logic [7:0] phase;
    logic pulse;
  } state_type;

  state_type cur;
  state_type next_cur;
  logic onGeneral;
  logic wrHit;
  logic stepEn;
  logic autoSquelch;
  logic [7:0] dutyLimited;

  assign onGeneral = (cur.page == PAGE_GENERAL);
  assign wrHit = mgmtReq.write && onGeneral;
  assign stepEn = (cur.stepCnt == STEP_LAST);
  assign dutyLimited = (cur.duty > DUTY_MAX) ? DUTY_MAX : cur.duty;

  // Automatic squelch decision per level
  always_comb begin
    autoSquelch = 1'b1;
    unique case (cur.rcSquelch)
      SQ_STRICT: autoSquelch = !linkStatus.up || !linkStatus.stable || linkStatus.speed10
        || linkStatus.eee;
      SQ_RELAXED: autoSquelch = !linkStatus.up || !linkStatus.stable
        || (linkStatus.eee && !linkStatus.lpIdle);
      SQ_LINKDOWN: autoSquelch = !linkStatus.up;
      SQ_NONE: autoSquelch = 1'b0;
    endcase
  end

  // Next state: register writes, reads, pin sync, output staging
  always_comb begin
    next_cur = cur;
    next_cur.holdSync1 = holdPinIn;
    next_cur.holdSync2 = cur.holdSync1;
    next_cur.sqSync1 = squelchPinIn;
    next_cur.sqSync2 = cur.sqSync1;
    next_cur.rdValid = mgmtReq.read;
    next_cur.rdData = 16'h0000;
    // Page select is visible on every page
    if (mgmtReq.write && mgmtReq.addr == ADDR_PAGE) begin
      next_cur.page = mgmtReq.data;
    end
    // Writable fields only; reserved bits are dropped
    if (wrHit) begin
      unique case (mgmtReq.addr)
        ADDR_PIN_LED: begin
          next_cur.holdDirIn = mgmtReq.data[HOLD_DIR_BIT];
          next_cur.holdOutData = mgmtReq.data[HOLD_OUT_BIT];
          next_cur.ledTri = mgmtReq.data[LED_TRI_BIT];
        end
        ADDR_ALERT: next_cur.alertSel = mgmtReq.data[ALERT_LSB +: 4];
        ADDR_RECCLK: begin
          next_cur.rcEnable = mgmtReq.data[RC_EN_BIT];
          next_cur.rcFreq = mgmtReq.data[RC_FREQ_LSB +: 3];
          next_cur.rcSquelch = mgmtReq.data[RC_SQ_LSB +: 2];
          next_cur.rcSource = mgmtReq.data[RC_SRC_LSB +: 3];
        end
        ADDR_DUTY: next_cur.duty = mgmtReq.data[DUTY_LSB +: 8];
        default: ;
      endcase
    end
    // Read data; unmapped and reserved bits return zero
    if (mgmtReq.read) begin
      if (mgmtReq.addr == ADDR_PAGE) begin
        next_cur.rdData = cur.page;
      end else if (onGeneral) begin
        unique case (mgmtReq.addr)
          ADDR_PIN_LED: begin
            next_cur.rdData[HOLD_DIR_BIT] = cur.holdDirIn;
            next_cur.rdData[HOLD_OUT_BIT] = cur.holdOutData;
            next_cur.rdData[HOLD_IN_BIT] = cur.holdSync2;
            next_cur.rdData[LED_TRI_BIT] = cur.ledTri;
          end
          ADDR_ALERT: next_cur.rdData[ALERT_LSB +: 4] = cur.alertSel;
          ADDR_RECCLK: begin
            next_cur.rdData[RC_EN_BIT] = cur.rcEnable;
            next_cur.rdData[RC_FREQ_LSB +: 3] = cur.rcFreq;
            next_cur.rdData[RC_SQ_LSB +: 2] = cur.rcSquelch;
            next_cur.rdData[RC_SRC_LSB +: 3] = cur.rcSource;
          end
          ADDR_DUTY: next_cur.rdData[DUTY_LSB +: 8] = cur.duty;
          default: next_cur.rdData = 16'h0000;
        endcase
      end
    end
    // Alert pin follows the event only with the enable code
    next_cur.alertOut = (cur.alertSel == ALERT_ON) && linkDropEvent;
    // Recovered clock gate: enable, valid source and frequency, no squelch
    next_cur.rcGate = cur.rcEnable && (cur.rcSource == SRC_COPPER)
      && (cur.rcFreq == FREQ_25 || cur.rcFreq == FREQ_125 || cur.rcFreq == FREQ_31P25)
      && !autoSquelch && !cur.sqSync2;
    // Pulse phase: 200 steps of 0.5%, high for N+1 steps
    next_cur.stepCnt = stepEn ? 8'h00 : cur.stepCnt + 8'h01;
    if (stepEn) begin
      next_cur.phase = (cur.phase == PHASE_LAST) ? 8'h00 : cur.phase + 8'h01;
    end
    next_cur.pulse = (next_cur.phase <= dutyLimited);
    // PHY reset clears transient state only; bank bits stay
    if (phyReset) begin
      next_cur.page = PAGE_MAIN;
      next_cur.rdValid = 1'b0;
      next_cur.rdData = 16'h0000;
      next_cur.alertOut = 1'b0;
      next_cur.rcGate = 1'b0;
      next_cur.stepCnt = 8'h00;
      next_cur.phase = 8'h00;
      next_cur.pulse = 1'b1;
    end
  end

  // State register; power-on reset loads the bank defaults
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cur <= '0;
      cur.holdDirIn <= HOLD_DIR_RESET;
      cur.holdOutData <= HOLD_OUT_RESET;
      cur.ledTri <= LED_TRI_RESET;
      cur.alertSel <= ALERT_ON;
      cur.rcEnable <= RC_EN_RESET;
      cur.rcFreq <= FREQ_25;
      cur.rcSquelch <= SQ_STRICT;
      cur.rcSource <= SRC_RESET;
      cur.duty <= DUTY_RESET;
      cur.page <= PAGE_MAIN;
      cur.pulse <= 1'b1;
    end else begin
      cur <= next_cur;
    end
  end

  // Pin and status outputs
  assign mgmtRdData = cur.rdData;
  assign mgmtRdValid = cur.rdValid;
  assign generalPageSelected = onGeneral;
  assign holdPinOe = !cur.holdDirIn;
  assign holdPinOut = cur.holdOutData;
  assign linkDropAlertOut = cur.alertOut;
  assign linkDropAlertOe = (cur.alertSel == ALERT_ON);
  assign recClkGate = cur.rcGate;
  assign recClkFreqSel = cur.rcFreq;

  // LEDs active low; tri-state mode floats instead of driving high
  for (genvar i = 0; i < NUM_LEDS; i++) begin : g_led
    logic lit;
    assign lit = ledOn[i] && (!ledPulseEnable || cur.pulse);
    assign ledOut[i] = !lit;
    assign ledOe[i] = cur.ledTri ? lit : 1'b1;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  // Register port, hold pin, LED drive and alert pin checks
  sequence s_readPinReg;
    mgmtReq.read && onGeneral && mgmtReq.addr == ADDR_PIN_LED && !phyReset;
  endsequence
  sequence s_holdHigh;
    holdPinIn [*3];
  endsequence
  sequence s_squelchHeld;
    squelchPinIn [*3];
  endsequence

  property p_holdDir;
    (holdPinOe == !cur.holdDirIn) && (!holdPinOe || holdPinOut == cur.holdOutData);
  endproperty
  a_holdDir: assert property (p_holdDir) else $error("hold pin drive wrong");
  property p_holdWrite;
    (wrHit && mgmtReq.addr == ADDR_PIN_LED && !phyReset) |=>
      holdPinOe == !$past(mgmtReq.data[HOLD_DIR_BIT])
      && holdPinOut == $past(mgmtReq.data[HOLD_OUT_BIT]);
  endproperty
  a_holdWrite: assert property (p_holdWrite) else $error("hold pin write lost");
  property p_holdRead;
    s_holdHigh ##0 s_readPinReg |=> mgmtRdValid && mgmtRdData[HOLD_IN_BIT];
  endproperty
  a_holdRead: assert property (p_holdRead) else $error("hold pin level not read");
  property p_pageEnter;
    (mgmtReq.write && mgmtReq.addr == ADDR_PAGE && mgmtReq.data == PAGE_GENERAL && !phyReset)
      |=> generalPageSelected;
  endproperty
  a_pageEnter: assert property (p_pageEnter) else $error("page select not taken");
  property p_pageLeave;
    (mgmtReq.write && mgmtReq.addr == ADDR_PAGE && mgmtReq.data == PAGE_MAIN)
      |=> !generalPageSelected;
  endproperty
  a_pageLeave: assert property (p_pageLeave) else $error("main page not restored");
  property p_ledTri;
    cur.ledTri |-> ((ledOe & ledOut) == '0);
  endproperty
  a_ledTri: assert property (p_ledTri) else $error("LED driven high in tri-state");
  property p_ledDrive;
    !cur.ledTri |-> (&ledOe);
  endproperty
  a_ledDrive: assert property (p_ledDrive) else $error("LED not driven both ways");
  property p_alertOff;
    (cur.alertSel == ALERT_OFF) |-> !linkDropAlertOe ##1 !linkDropAlertOut;
  endproperty
  a_alertOff: assert property (p_alertOff) else $error("alert pin not disabled");
  property p_alertFollow;
    (cur.alertSel == ALERT_ON && linkDropEvent && !phyReset) |=> linkDropAlertOut;
  endproperty
  a_alertFollow: assert property (p_alertFollow) else $error("alert event not shown");
  // Recovered clock checks, then the minimum pulse duty check
  property p_rcDisable;
    !cur.rcEnable |=> !recClkGate;
  endproperty
  a_rcDisable: assert property (p_rcDisable) else $error("clock passes while off");
  property p_rcSource;
    (cur.rcSource != SRC_COPPER) |=> !recClkGate;
  endproperty
  a_rcSource: assert property (p_rcSource) else $error("reserved source passes");
  property p_freqRsvd;
    (cur.rcFreq != FREQ_25 && cur.rcFreq != FREQ_125 && cur.rcFreq != FREQ_31P25)
      |=> !recClkGate;
  endproperty
  a_freqRsvd: assert property (p_freqRsvd) else $error("reserved rate passes");
  property p_freqOut;
    (wrHit && mgmtReq.addr == ADDR_RECCLK) |=>
      recClkFreqSel == $past(mgmtReq.data[RC_FREQ_LSB +: 3]);
  endproperty
  a_freqOut: assert property (p_freqOut) else $error("frequency select not applied");
  property p_sqStrict;
    (cur.rcSquelch == SQ_STRICT
      && (linkStatus.speed10 || linkStatus.eee || !linkStatus.stable)) |=> !recClkGate;
  endproperty
  a_sqStrict: assert property (p_sqStrict) else $error("10BASE-T not squelched");
  property p_sqRelaxed;
    (cur.rcSquelch == SQ_RELAXED && cur.rcEnable && cur.rcSource == SRC_COPPER
      && cur.rcFreq == FREQ_25 && !cur.sqSync2 && !phyReset && linkStatus.up
      && linkStatus.stable && linkStatus.eee && linkStatus.lpIdle) |=> recClkGate;
  endproperty
  a_sqRelaxed: assert property (p_sqRelaxed) else $error("idle clock squelched");
  property p_sqLinkDown;
    (cur.rcSquelch == SQ_LINKDOWN && !linkStatus.up) |=> !recClkGate;
  endproperty
  a_sqLinkDown: assert property (p_sqLinkDown) else $error("clock with link down");
  property p_sqNone;
    (cur.rcSquelch == SQ_NONE && cur.rcEnable && cur.rcSource == SRC_COPPER
      && cur.rcFreq == FREQ_125 && !cur.sqSync2 && !phyReset) |=> recClkGate;
  endproperty
  a_sqNone: assert property (p_sqNone) else $error("clock squelched with squelch off");
  property p_squelchPin;
    s_squelchHeld |=> !recClkGate;
  endproperty
  a_squelchPin: assert property (p_squelchPin) else $error("pin did not squelch");
  property p_dutyMin;
    (stepEn && cur.phase == 8'h00 && dutyLimited == DUTY_RESET && !phyReset) |=> !cur.pulse;
  endproperty
  a_dutyMin: assert property (p_dutyMin) else $error("minimum duty too long");
  // LED pulse checks, then PHY reset and reserved bit checks
  property p_dutyMax;
    (stepEn && cur.phase == DUTY_MAX && dutyLimited == DUTY_MAX && !phyReset) |=> !cur.pulse;
  endproperty
  a_dutyMax: assert property (p_dutyMax) else $error("maximum duty too long");
  property p_dutyWrap;
    (stepEn && cur.phase == PHASE_LAST && !phyReset) |=> cur.pulse;
  endproperty
  a_dutyWrap: assert property (p_dutyWrap) else $error("pulse not lit at period start");
  property p_pulseDark;
    (ledPulseEnable && !cur.pulse) |-> (&ledOut);
  endproperty
  a_pulseDark: assert property (p_pulseDark) else $error("LED lit in dark phase");
  property p_sticky;
    (phyReset && !mgmtReq.write) |=> cur.duty == $past(cur.duty)
      && cur.rcEnable == $past(cur.rcEnable) && cur.holdDirIn == $past(cur.holdDirIn);
  endproperty
  a_sticky: assert property (p_sticky) else $error("bank lost on PHY reset");
  property p_reservedZero;
    (mgmtReq.read && onGeneral && mgmtReq.addr == ADDR_ALERT && !phyReset) |=>
      mgmtRdData[15:4] == 12'h000;
  endproperty
  a_reservedZero: assert property (p_reservedZero) else $error("reserved bits set");

endmodule // phy_general_purpose_regs

// *** sim/mgmt_host_model.sv ***
// Management host model: page select, register writes and reads.
// Assumes requests change on the falling edge of core_clk.
`timescale 1ns/1ps
module mgmt_host_model
  import phy_gp_regs_pkg::*;
(
  input wire logic core_clk,
  output mgmt_req_type mgmtReq,
  input wire logic [15:0] mgmtRdData,
  input wire logic mgmtRdValid
);
  // Idle request with a junk data pattern
  initial mgmtReq = '{addr: 5'h00, write: 1'b0, read: 1'b0, data: 16'ha5a5};

  // One-cycle write strobe; data inverted once released
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge core_clk);
    mgmtReq.addr = a;
    mgmtReq.data = d;
    mgmtReq.write = 1'b1;
    @(negedge core_clk);
    mgmtReq.write = 1'b0;
    mgmtReq.data = ~d;
  endtask

  // One-cycle read strobe; answer stands one cycle later
  task automatic rd(input logic [4:0] a, output logic [15:0] d, output logic v);
    @(negedge core_clk);
    mgmtReq.addr = a;
    mgmtReq.read = 1'b1;
    @(negedge core_clk);
    mgmtReq.read = 1'b0;
    v = mgmtRdValid;
    d = mgmtRdData;
  endtask

  // Page register select
  task automatic page(input logic [15:0] p);
    wr(ADDR_PAGE, p);
  endtask
endmodule // mgmt_host_model

// *** sim/phy_general_purpose_regs_tb.sv ***
// Self-checking bench for the general purpose register bank.
// Assumes the host model drives requests; pins are driven here on falling edges.
`timescale 1ns/1ps
module phy_general_purpose_regs_tb
  import phy_gp_regs_pkg::*;
;
  typedef struct packed {logic [4:0] a; logic [15:0] d; logic [15:0] r;} row_type;
  logic core_clk, reset, phyReset, extHold, holdPinIn, holdPinOut, holdPinOe;
  logic ledPulseEnable, linkDropEvent, linkDropAlertOut, linkDropAlertOe;
  logic squelchPinIn, recClkGate, mgmtRdValid, generalPageSelected;
  logic [1:0] ledOn, ledOut, ledOe;
  logic [2:0] recClkFreqSel;
  logic [15:0] mgmtRdData, rdv, cnt;
  logic vld;
  mgmt_req_type mgmtReq;
  link_status_type linkStatus;
  int numErrors = 0;
  int cmpCount = 0;
  row_type rows [14] = '{
    '{5'h0e, 16'hffff, 16'h3a00}, '{5'h0e, 16'h1000, 16'h1800},
    '{5'h0e, 16'h0000, 16'h0000}, '{5'h0e, 16'h2200, 16'h2a00},
    '{5'h13, 16'hffff, 16'h000f}, '{5'h13, 16'h0005, 16'h0005},
    '{5'h13, 16'h0000, 16'h0000}, '{5'h17, 16'hffff, 16'h8737},
    '{5'h17, 16'h0211, 16'h0211}, '{5'h17, 16'h8031, 16'h8031},
    '{5'h19, 16'hc6ab, 16'hc600}, '{5'h19, 16'h0000, 16'h0000},
    '{5'h00, 16'hffff, 16'h0000}, '{5'h0d, 16'hffff, 16'h0000}};
  logic [4:0] links [6] = '{5'b00000, 5'b10000, 5'b11100, 5'b11010, 5'b11011, 5'b11000};
  logic [3:0] masks [6] = '{4'b1000, 4'b1100, 4'b1110, 4'b1100, 4'b1110, 4'b1111};

  // Hold pin wire: design drive wins, else the external level
  assign holdPinIn = holdPinOe ? holdPinOut : extHold;

  phy_general_purpose_regs i_phy_general_purpose_regs (.core_clk(core_clk), .reset(reset),
    .phyReset(phyReset), .mgmtReq(mgmtReq), .mgmtRdData(mgmtRdData),
    .mgmtRdValid(mgmtRdValid), .generalPageSelected(generalPageSelected),
    .holdPinIn(holdPinIn), .holdPinOut(holdPinOut), .holdPinOe(holdPinOe), .ledOn(ledOn),
    .ledPulseEnable(ledPulseEnable), .ledOut(ledOut), .ledOe(ledOe),
    .linkDropEvent(linkDropEvent), .linkDropAlertOut(linkDropAlertOut),
    .linkDropAlertOe(linkDropAlertOe), .linkStatus(linkStatus),
    .squelchPinIn(squelchPinIn), .recClkGate(recClkGate), .recClkFreqSel(recClkFreqSel));
  mgmt_host_model i_mgmt_host_model (.core_clk(core_clk), .mgmtReq(mgmtReq),
    .mgmtRdData(mgmtRdData), .mgmtRdValid(mgmtRdValid));

  // 25 MHz clock
  always #20 core_clk = ~core_clk;

  // Compare and count
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmpCount++;
    if (got !== exp) begin
      numErrors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Read one register and compare the answer
  task automatic rdchk(input logic [4:0] a, input logic [15:0] exp);
    i_mgmt_host_model.rd(a, rdv, vld);
    check(16'(vld), 16'h0001);
    check(rdv, exp);
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  // Verdict and end of run
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmpCount, numErrors);
    if (numErrors == 0 && cmpCount > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    repeat (90000) @(posedge core_clk);
    numErrors++;
    results();
  end

  // Main sequence
  initial begin
    core_clk = 1'b0;
    reset = 1'b1;
    phyReset = 1'b0;
    extHold = 1'b0;
    ledOn = 2'b00;
    ledPulseEnable = 1'b0;
    linkDropEvent = 1'b0;
    linkStatus = '0;
    squelchPinIn = 1'b0;
    repeat (8) @(posedge core_clk);
    @(negedge core_clk);
    reset = 1'b0;
    check({holdPinOe, linkDropAlertOe, recClkGate, recClkFreqSel}, 16'h0010);
    i_mgmt_host_model.page(PAGE_GENERAL);
    check(16'(generalPageSelected), 16'h0001);
    rdchk(ADDR_PIN_LED, 16'h2200);
    rdchk(ADDR_ALERT, 16'h0000);
    rdchk(ADDR_RECCLK, 16'h0000);
    rdchk(ADDR_DUTY, 16'h0000);
    // Table rows: write, let pins settle, read back
    extHold = 1'b1;
    foreach (rows[i]) begin
      i_mgmt_host_model.wr(rows[i].a, rows[i].d);
      idle(4);
      rdchk(rows[i].a, rows[i].r);
      if (rows[i].a == ADDR_PIN_LED) check(16'(holdPinOe), 16'(!rows[i].r[13]));
      if (rows[i].a == ADDR_ALERT) check(16'(linkDropAlertOe), 16'(rows[i].r == 0));
      if (rows[i].a == ADDR_RECCLK) check(16'(recClkFreqSel), 16'(rows[i].r[10:8]));
    end
    // LED drive with tri-state set, then cleared
    ledOn = 2'b01;
    idle(2);
    check({ledOe, ledOut[0]}, 16'h0002);
    i_mgmt_host_model.wr(ADDR_PIN_LED, 16'h2000);
    idle(2);
    check({ledOe, ledOut}, 16'h000e);
    // Squelch levels against link conditions
    for (int sq = 0; sq < 4; sq++) begin
      i_mgmt_host_model.wr(ADDR_RECCLK, 16'h8001 | 16'(sq << 4));
      for (int k = 0; k < 6; k++) begin
        linkStatus = links[k];
        idle(4);
        check(16'(recClkGate), 16'(masks[k][sq]));
      end
    end
    squelchPinIn = 1'b1;
    idle(5);
    check(16'(recClkGate), 16'h0000);
    squelchPinIn = 1'b0;
    i_mgmt_host_model.wr(ADDR_RECCLK, 16'h0031);
    idle(4);
    check(16'(recClkGate), 16'h0000);
    i_mgmt_host_model.wr(ADDR_RECCLK, 16'h8030);
    idle(4);
    check(16'(recClkGate), 16'h0000);
    i_mgmt_host_model.wr(ADDR_RECCLK, 16'h8331);
    idle(4);
    check(16'(recClkGate), 16'h0000);
    i_mgmt_host_model.wr(ADDR_RECCLK, 16'h8131);
    idle(4);
    check({recClkGate, recClkFreqSel}, 16'h0009);
    // Alert pin enabled, then disabled
    linkDropEvent = 1'b1;
    idle(3);
    check({linkDropAlertOe, linkDropAlertOut}, 16'h0003);
    i_mgmt_host_model.wr(ADDR_ALERT, 16'h000f);
    idle(3);
    check({linkDropAlertOe, linkDropAlertOut}, 16'h0000);
    // PHY reset keeps the bank; main page ignores bank writes
    i_mgmt_host_model.wr(ADDR_DUTY, 16'h1200);
    phyReset = 1'b1;
    idle(1);
    phyReset = 1'b0;
    check(16'(generalPageSelected), 16'h0000);
    i_mgmt_host_model.wr(ADDR_DUTY, 16'h3400);
    i_mgmt_host_model.page(PAGE_GENERAL);
    rdchk(ADDR_DUTY, 16'h1200);
    // Pulse duty 198: lit for 199 of 200 steps of 250 cycles
    i_mgmt_host_model.wr(ADDR_DUTY, 16'hc600);
    ledOn = 2'b11;
    ledPulseEnable = 1'b1;
    cnt = '0;
    repeat (50000) begin
      @(negedge core_clk);
      if (ledOut[0] === 1'b0) cnt++;
    end
    check(cnt, 16'(199 * 250));
    // Mid-run power-on reset reloads the bank defaults
    reset = 1'b1;
    idle(2);
    reset = 1'b0;
    check({holdPinOe, linkDropAlertOe, recClkGate, recClkFreqSel}, 16'h0010);
    i_mgmt_host_model.page(PAGE_GENERAL);
    rdchk(ADDR_PIN_LED, 16'h2a00);
    rdchk(ADDR_RECCLK, 16'h0000);
    i_mgmt_host_model.page(PAGE_MAIN);
    check(16'(generalPageSelected), 16'h0000);
    results();
  end
endmodule // phy_general_purpose_regs_tb
